// [lcd_cmd_consts.vh]
// constants for the lcd driver two-wire command decoder
// assumes inclusion by bare name from the decoder
`ifndef LCD_CMD_CONSTS_VH
`define LCD_CMD_CONSTS_VH
// slave address upper bits (arbitrary fixed prefix 01111, strap bits below)
`define ADDR_PREFIX 5'h0F
// control byte field positions
`define CTL_CONT_BIT 7
`define CTL_SEL_BIT 6
// command pages
`define PAGE_FUNC 3'h7
`define PAGE_DISP 3'h6
`define PAGE_HV 3'h5
// reset values
`define RST_PAGE 3'h7
`define RST_BIAS 3'h0
`define RST_MUX 3'h0
`define RST_MULT 2'h0
`define RST_TC 3'h0
`define RST_VOP 7'h00
// array geometry
`define X_LAST 8'h84
`define Y_LAST 4'h8
// mux rate 1:65 code in the low field
`define MUX_65 3'h4
`endif

// [lcd_ram.v]
// display data memory: one byte per column per bank, registered read
// assumes a single clock shared with the decoder
`timescale 1ns/1ps
`default_nettype none
module lcd_ram #(
  parameter AW = 12
) (
  input wire clk_sys_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [7:0] rdata_o
);
  reg [7:0] mem [0:(1<<AW)-1];
  // ====================
  // write and registered read
  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// [lcd_i2c_decoder.v]
// two-wire command decoder of a dot-matrix lcd driver
// assumes scl and sda arrive asynchronously and are oversampled by clk_sys_i
// Functional notes
// - start, address with write flag, strap match
// - continuation set, select clear: one command
// - continuation clear, select set: stream to ram
// - 00000xxx returns to function page (except 000001xx on hv page), 00001xxx there selects page
// - function page code 110 selects display page
// - function page code 101 selects hv page
// - display page loads bias field
// - display page bit7 sets mux rate
// - display control decodes display on, inverse
// - hv page 000010xx loads multiplier factor
// - hv page 00010xxx loads temperature coefficient
// - hv page bit7 loads operating voltage
// - hv page loads range and multiplier enable
// - x and y counters reset to zero
// - function page bit7 sets x address
// - continuation set: control byte after each byte
// - select set: byte stored at current address
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cmd_consts.vh"
module lcd_i2c_decoder #(
  parameter AW = 12
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire address_strap_low_i,
  input wire address_strap_high_i,
  input wire [AW-1:0] ram_raddr_i,
  output wire [7:0] ram_rdata_o,
  output reg [2:0] page_o,
  output reg power_down_bit_o,
  output reg vertical_o,
  output reg [2:0] bias_ratio_field_o,
  output reg [2:0] mux_rate_o,
  output reg display_on_o,
  output reg inverse_o,
  output reg [1:0] mult_factor_o,
  output reg [2:0] temp_coefficient_field_o,
  output reg [6:0] operating_voltage_field_o,
  output reg high_range_select_o,
  output reg multiplier_enable_o,
  output reg [7:0] x_addr_o,
  output reg [3:0] y_addr_o
);
  // ====================
  // pin synchronisers
  reg scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  // straps are pins as well, so they pass the same two flops
  reg strap_lo_m, strap_lo_s, strap_hi_m, strap_hi_s;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      strap_lo_m <= 1'b0;
      strap_lo_s <= 1'b0;
      strap_hi_m <= 1'b0;
      strap_hi_s <= 1'b0;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
      strap_lo_m <= address_strap_low_i;
      strap_lo_s <= strap_lo_m;
      strap_hi_m <= address_strap_high_i;
      strap_hi_s <= strap_hi_m;
    end
  end
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;

  // ====================
  // byte framing state
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CTRL = 3'h2;
  localparam ST_CMD = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_CMDS = 3'h5;
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg ack_phase;
  reg byte_done;
  reg cont_flag;
  reg [7:0] rx_byte;
  reg ram_we;
  reg [7:0] ram_wdata;
  reg [AW-1:0] ram_waddr;

  // ram address from bank and column
  function [AW-1:0] ram_index;
    input [3:0] y;
    input [7:0] x;
    begin
      ram_index = y * 12'd256 + {4'h0, x};
    end
  endfunction

  // shift bits on rising scl; ack low on the ninth clock
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ack_phase <= 1'b0;
      byte_done <= 1'b0;
      rx_byte <= 8'h00;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      cont_flag <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      sda_o <= 1'b0;
      if (start_c) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (state != ST_IDLE) begin
        if (scl_rise && !ack_phase) begin
          shreg <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
        if (scl_fall && ack_phase) begin
          ack_phase <= 1'b0;
          sda_oe_o <= 1'b0;
        end else if (scl_fall && bitcnt == 4'h8) begin
          bitcnt <= 4'h0;
          ack_phase <= 1'b1;
          rx_byte <= shreg;
          byte_done <= 1'b1;
          case (state)
            ST_ADDR: begin
              // only a write with matching straps is answered
              if (shreg[7:3] == `ADDR_PREFIX && shreg[2] == strap_hi_s &&
                  shreg[1] == strap_lo_s && !shreg[0]) begin
                state <= ST_CTRL;
                sda_oe_o <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
            ST_CTRL: begin
              sda_oe_o <= 1'b1;
              cont_flag <= shreg[`CTL_CONT_BIT];
              if (shreg[`CTL_SEL_BIT]) begin
                state <= ST_DATA;
              end else begin
                state <= ST_CMD;
              end
            end
            ST_CMD: begin
              sda_oe_o <= 1'b1;
              state <= cont_flag ? ST_CTRL : ST_CMDS;
            end
            ST_DATA: begin
              sda_oe_o <= 1'b1;
              state <= cont_flag ? ST_CTRL : ST_DATA;
            end
            ST_CMDS: begin
              sda_oe_o <= 1'b1;
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // which kind of byte just completed, latched with the byte
  reg [2:0] done_kind;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      done_kind <= ST_IDLE;
    end else if (scl_fall && bitcnt == 4'h8 && !ack_phase) begin
      done_kind <= state;
    end
  end

  // ====================
  // command decode and ram writes; fields survive stop and restart
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      page_o <= `RST_PAGE;
      power_down_bit_o <= 1'b1;
      vertical_o <= 1'b0;
      bias_ratio_field_o <= `RST_BIAS;
      mux_rate_o <= `RST_MUX;
      display_on_o <= 1'b0;
      inverse_o <= 1'b0;
      mult_factor_o <= `RST_MULT;
      temp_coefficient_field_o <= `RST_TC;
      operating_voltage_field_o <= `RST_VOP;
      high_range_select_o <= 1'b0;
      multiplier_enable_o <= 1'b0;
      x_addr_o <= 8'h00;
      y_addr_o <= 4'h0;
      ram_we <= 1'b0;
      ram_wdata <= 8'h00;
      ram_waddr <= {AW{1'b0}};
    end else begin
      ram_we <= 1'b0;
      if (byte_done && (done_kind == ST_CMD || done_kind == ST_CMDS)) begin
        // 000001xx on the hv page is the range command, not a page return
        if (rx_byte[7:3] == 5'h00 && !(page_o == `PAGE_HV && rx_byte[2])) begin
          page_o <= `PAGE_FUNC;
        end else begin
          case (page_o)
            `PAGE_FUNC: begin
              if (rx_byte[7]) begin
                x_addr_o <= (rx_byte[6:0] > `X_LAST) ? 8'h00 : {1'b0, rx_byte[6:0]};
              end else if (rx_byte[7:6] == 2'h1) begin
                y_addr_o <= (rx_byte[3:0] > `Y_LAST) ? 4'h0 : rx_byte[3:0];
              end else if (rx_byte[7:4] == 4'h1) begin
                power_down_bit_o <= rx_byte[2];
                vertical_o <= rx_byte[1];
              end else if (rx_byte[7:3] == 5'h01) begin
                page_o <= rx_byte[2:0];
              end
            end
            `PAGE_DISP: begin
              if (rx_byte[7]) begin
                mux_rate_o <= rx_byte[2:0];
              end else if (rx_byte[7:3] == 5'h02) begin
                bias_ratio_field_o <= rx_byte[2:0];
              end else if (rx_byte[7:3] == 5'h01) begin
                display_on_o <= rx_byte[2];
                inverse_o <= rx_byte[0];
              end
            end
            `PAGE_HV: begin
              if (rx_byte[7]) begin
                operating_voltage_field_o <= rx_byte[6:0];
              end else if (rx_byte[7:3] == 5'h02) begin
                temp_coefficient_field_o <= rx_byte[2:0];
              end else if (rx_byte[7:2] == 6'h02) begin
                mult_factor_o <= rx_byte[1:0];
              end else if (rx_byte[7:2] == 6'h01) begin
                high_range_select_o <= rx_byte[1];
                multiplier_enable_o <= rx_byte[0];
              end
            end
            default: begin
              page_o <= page_o;
            end
          endcase
        end
      end else if (byte_done && done_kind == ST_DATA) begin
        ram_we <= 1'b1;
        ram_wdata <= rx_byte;
        ram_waddr <= ram_index(y_addr_o, x_addr_o);
        // advance along the chosen direction, wrapping at the array edge
        if (vertical_o) begin
          if (y_addr_o == `Y_LAST) begin
            y_addr_o <= 4'h0;
            x_addr_o <= (x_addr_o == `X_LAST) ? 8'h00 : x_addr_o + 8'h01;
          end else begin
            y_addr_o <= y_addr_o + 4'h1;
          end
        end else begin
          if (x_addr_o == `X_LAST) begin
            x_addr_o <= 8'h00;
            y_addr_o <= (y_addr_o == `Y_LAST) ? 4'h0 : y_addr_o + 4'h1;
          end else begin
            x_addr_o <= x_addr_o + 8'h01;
          end
        end
      end
    end
  end

  // ====================
  // display memory; read port is for the display scan side
  lcd_ram #(.AW(AW)) u_ram (
    .clk_sys_i(clk_sys_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(ram_raddr_i),
    .rdata_o(ram_rdata_o)
  );
endmodule
`default_nettype wire

// [i2c_host_model.sv]
// two-wire bus master model that drives the decoder's scl and sda pins
// assumes the device pulls sda low with its enable; both lines pulled up
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clk_sys_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output wire logic sda_o
);
  // ==========================================================
  // line drivers
  logic drv = 1'b1;
  logic ack = 1'b0;
  initial scl_o = 1'b1;
  // wired line: pull-up wins unless someone pulls low
  assign sda_o = drv & ~sda_oe_i;
  // quarter of the 160 ns link period, moved just after an edge
  task automatic qtr(input int n);
    repeat (4 * n) @(posedge clk_sys_i);
    #1;
  endtask
  // data moves only while scl is low, read back in the high phase
  task automatic bit_(input logic b);
    drv = b;
    qtr(1);
    scl_o = 1'b1;
    qtr(1);
    ack = ~sda_o;
    qtr(1);
    scl_o = 1'b0;
    qtr(1);
  endtask
  // start from idle: sda falls while scl is high
  task automatic start();
    drv = 1'b1;
    scl_o = 1'b1;
    qtr(1);
    drv = 1'b0;
    qtr(1);
    scl_o = 1'b0;
    qtr(1);
  endtask
  // eight bits msb first, ninth clock released for the ack
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_(b[i]);
    bit_(1'b1);
  endtask
  // stop: sda rises while scl is high, then both lines stand still
  task automatic stop();
    drv = 1'b0;
    qtr(1);
    scl_o = 1'b1;
    qtr(1);
    drv = 1'b1;
    qtr(2);
  endtask
endmodule
`default_nettype wire

// [lcd_i2c_decoder_sva.sv]
// assertions on the pins of the two-wire command decoder
// assumes binding into lcd_i2c_decoder, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lcd_i2c_decoder_sva (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [2:0] page_o,
  input wire logic [2:0] bias_ratio_field_o,
  input wire logic [6:0] operating_voltage_field_o,
  input wire logic [7:0] x_addr_o,
  input wire logic [3:0] y_addr_o
);
  // ==========================================================
  // ack timing and update moments
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  rst_vals_a: assert property (disable iff (1'b0) rst_i |->
    page_o == 3'h7 && x_addr_o == 8'h00 && y_addr_o == 4'h0) else $error("reset state");
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  ack_phase_a: assert property ($rose(sda_oe_o) |->
    !scl_i && !$past(scl_i, 2)) else $error("ack began in high phase");
  ack_len_a: assert property ($rose(sda_oe_o) |->
    sda_oe_o [*8] ##[1:20] !sda_oe_o) else $error("ack width wrong");
  page_when_a: assert property (!$stable(page_o) |-> !scl_i)
    else $error("page moved in high phase");
  field_when_a: assert property (
    !$stable({bias_ratio_field_o, operating_voltage_field_o}) |-> !scl_i)
    else $error("field moved in high phase");
  addr_when_a: assert property (!$stable({y_addr_o, x_addr_o}) |-> !scl_i)
    else $error("address moved in high phase");
  addr_range_a: assert property (x_addr_o <= 8'h84 && y_addr_o <= 4'h8)
    else $error("address past array edge");
endmodule
bind lcd_i2c_decoder lcd_i2c_decoder_sva lcd_i2c_decoder_sva_i (.clk_sys_i, .rst_i,
  .scl_i, .sda_o, .sda_oe_o, .page_o, .bias_ratio_field_o, .operating_voltage_field_o,
  .x_addr_o, .y_addr_o);
`default_nettype wire

// [lcd_i2c_decoder_bench.sv]
// self-checking bench of the two-wire command decoder against a reference
// assumes the host model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module lcd_i2c_decoder_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b0;
  logic sa_lo = 1'b0;
  logic sa_hi = 1'b1;
  logic [11:0] raddr = 12'h000;
  logic [31:0] seed = 32'h00012D6C;
  logic [7:0] adr;
  logic [7:0] q[$];
  wire scl, sda, oe, pd, vt, don, inv, high_range_select, multiplier_enable;
  wire [7:0] rdata, xa;
  wire [3:0] ya;
  wire [2:0] pg, bias, mux, tc;
  wire [1:0] mf;
  wire [6:0] vop;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  // ==========================================================
  // reference state, starting at reset values
  logic [2:0] m_pg = 3'h7, m_bias = 3'h0, m_mux = 3'h0, m_tc = 3'h0;
  logic [1:0] m_mf = 2'h0;
  logic [6:0] m_vop = 7'h00;
  logic [7:0] m_x = 8'h00;
  logic [3:0] m_y = 4'h0;
  logic m_pd = 1'b1, m_v = 1'b0, m_don = 1'b0, m_inv = 1'b0, m_prs = 1'b0, m_hve = 1'b0;
  logic [7:0] m_ram [int];
  // free-running 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;
  lcd_i2c_decoder lcd_i2c_decoder_i (.clk_sys_i, .rst_i, .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(oe), .address_strap_low_i(sa_lo), .address_strap_high_i(sa_hi),
    .ram_raddr_i(raddr), .ram_rdata_o(rdata), .page_o(pg), .power_down_bit_o(pd),
    .vertical_o(vt), .bias_ratio_field_o(bias), .mux_rate_o(mux), .display_on_o(don),
    .inverse_o(inv), .mult_factor_o(mf), .temp_coefficient_field_o(tc),
    .operating_voltage_field_o(vop), .high_range_select_o(high_range_select),
    .multiplier_enable_o(multiplier_enable), .x_addr_o(xa), .y_addr_o(ya));
  i2c_host_model i2c_host_model_i (.clk_sys_i, .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reference decode of one command byte; range bits first, they share 00000xxx
  task automatic cmd(input logic [7:0] b);
    if (m_pg == 3'h5 && b[7:2] == 6'h01) {m_prs, m_hve} = b[1:0];
    else if (b[7:3] == 5'h00) m_pg = 3'h7;
    else if (m_pg == 3'h7) begin
      if (b[7]) m_x = {1'b0, b[6:0]};
      else if (b[7:3] == 5'h01) m_pg = b[2:0];
      else if (b[7:4] == 4'h1) {m_pd, m_v} = b[2:1];
      else if (b[7:6] == 2'h1) m_y = (b[3:0] > 4'h8) ? 4'h0 : b[3:0];
    end else if (m_pg == 3'h6) begin
      if (b[7]) m_mux = b[2:0];
      else if (b[7:3] == 5'h02) m_bias = b[2:0];
      else if (b[7:3] == 5'h01) {m_don, m_inv} = {b[2], b[0]};
    end else if (m_pg == 3'h5) begin
      if (b[7]) m_vop = b[6:0];
      else if (b[7:3] == 5'h02) m_tc = b[2:0];
      else if (b[7:2] == 6'h02) m_mf = b[1:0];
    end
  endtask
  // ram byte at the current address, then advance along the direction with wrap
  task automatic dat(input logic [7:0] b);
    m_ram[{m_y, m_x}] = b;
    if (m_v) begin
      m_y = (m_y == 4'h8) ? 4'h0 : m_y + 4'h1;
      if (m_y == 4'h0) m_x = (m_x == 8'h84) ? 8'h00 : m_x + 8'h01;
    end else begin
      m_x = (m_x == 8'h84) ? 8'h00 : m_x + 8'h01;
      if (m_x == 8'h00) m_y = (m_y == 4'h8) ? 4'h0 : m_y + 4'h1;
    end
  endtask
  // compare every command output and every written ram byte with the reference
  task automatic check();
    repeat (4) @(posedge clk_sys_i);
    #1;
    `CHK(pg, m_pg)
    `CHK({pd, vt}, {m_pd, m_v})
    `CHK(bias, m_bias)
    `CHK(mux, m_mux)
    `CHK({don, inv}, {m_don, m_inv})
    `CHK(mf, m_mf)
    `CHK(tc, m_tc)
    `CHK(vop, m_vop)
    `CHK({high_range_select, multiplier_enable}, {m_prs, m_hve})
    `CHK({ya, xa}, {m_y, m_x})
    foreach (m_ram[a]) begin
      raddr = a[11:0];
      repeat (2) @(posedge clk_sys_i);
      #1;
      `CHK(rdata, m_ram[a])
    end
  endtask
  // one access of the bytes in q; a refused access leaves the reference alone
  task automatic xfer(input logic ok);
    int st = 0;
    logic dc = 1'b0;
    i2c_host_model_i.start();
    foreach (q[i]) begin
      i2c_host_model_i.put_byte(q[i]);
      `CHK(i2c_host_model_i.ack, ok)
      if (i > 0 && ok) begin
        if (st == 0) begin
          st = q[i][7] ? 1 : 2;
          dc = q[i][6];
        end else begin
          if (dc) dat(q[i]);
          else cmd(q[i]);
          if (st == 1) st = 0;
        end
      end
    end
    i2c_host_model_i.stop();
    check();
  endtask
  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  // setup, stream, chained commands, then wrong strap and read flag
  initial begin
    // raise reset off the clock edge so the async branch fires before any sample
    #1;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    check();
    adr = {5'h0F, sa_hi, sa_lo, 1'b0};
    q = '{adr, 8'h00, 8'h01, 8'h10, 8'h0E, 8'h12, 8'h0C, 8'h84, 8'h01, 8'h0D, 8'h09,
      8'h12, 8'hA8, 8'h07};
    xfer(1'b1);
    q = '{adr, 8'h40, 8'h1F, 8'h05, 8'h07, 8'h00, 8'h1F, 8'h04, 8'h1F};
    xfer(1'b1);
    // last bank, vertical stepping: the stream wraps to bank 0 of the next column
    q = '{adr, 8'h80, 8'h00, 8'h80, 8'h0E, 8'h80, 8'h0D, 8'h80, 8'h01, 8'h80, 8'h80,
      8'h80, 8'h48, 8'h80, 8'h12, 8'h40};
    repeat (3) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
    end
    xfer(1'b1);
    sa_lo = 1'b1;
    q = '{adr, 8'h00, 8'h0E};
    xfer(1'b0);
    q = '{8'h7F, 8'h00, 8'h0E};
    xfer(1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
